// ---- hw/uart_rx_status.sv ----
// Purpose: Serial receiver with two-entry buffer, error flags and receive interrupt.
// Assumes: The receive line is asynchronous; software uses the plain register port.
// Notes: Read data appear one cycle after the read strobe; a data read pops the buffer.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - Receive complete flag is one exactly while the buffer holds an unread entry.
// - Clearing the receiver enable bit flushes the buffer and drops the flag.
// - Interrupt stays high while flag, its enable and global enable are set.
// - Reading the data location pops the buffer; unread data keep the interrupt.
// - Frame, overrun and parity flags travel in the buffer with their character.
// - Software writes to the three error flag positions change nothing.
// - Error flags never raise an interrupt by themselves.
// - Frame error flag is one when the first stop bit sampled as zero.
// - Only the first stop bit is checked, whatever the stop bit setting.
// - Overrun when a start bit arrives with buffer full and a frame waiting.
// - Overrun is cleared once the waiting frame moves from holding stage to buffer.
// - Parity error flag reports failed parity and reads zero when checking is off.
// - After the first stop bit the frame moves into a free holding stage, unless mpcm_q is set and its addr_flag is clear.
// - Unused upper data bits read as zero for characters below eight bits.
module uart_rx_status #(
  parameter int FIFO_DEPTH = rx_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic rxd,
  input wire logic global_irq_en,
  input wire logic [rx_pkg::ADDR_W-1:0] addr,
  input wire logic [rx_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [rx_pkg::DATA_W-1:0] rdata,
  output logic rx_irq
);

  if (FIFO_DEPTH != 2) begin
    $error("uart_rx_status overrun detection assumes a two-entry buffer");
  end

  localparam int EW = $bits(rx_pkg::rx_entry_s);

  // Register file.
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_c_q;
  logic [11:0] baud_q;
  logic mpcm_q;
  logic [7:0] rdata_q;
  logic irq_q;

  // Line synchroniser and filtered level.
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic line_q;

  // Receiver.
  rx_pkg::rx_state_e state_q;
  logic [11:0] div_q;
  logic [3:0] ovs_q;
  logic [3:0] bit_q;
  logic [8:0] shreg_q;
  logic par_err_q;
  logic hold_valid_q;
  rx_pkg::rx_entry_s hold_q;
  logic ovr_pend_q;

  // Buffer side.
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_full;
  logic [EW-1:0] fifo_out;
  rx_pkg::rx_entry_s head;

  function automatic logic [7:0] size_mask(input logic [1:0] sz);
    case (sz)
      2'h0: size_mask = 8'h1f;
      2'h1: size_mask = 8'h3f;
      2'h2: size_mask = 8'h7f;
      default: size_mask = 8'hff;
    endcase
  endfunction

  wire rx_en = ctrl_b_q[rx_pkg::CB_RXEN_BIT];
  wire rxcie = ctrl_b_q[rx_pkg::CB_RXCIE_BIT];
  wire [1:0] par_mode = ctrl_c_q[rx_pkg::CC_PAR_HI:rx_pkg::CC_PAR_LO];
  wire [1:0] size_sel = ctrl_c_q[rx_pkg::CC_SIZE_HI:rx_pkg::CC_SIZE_LO];
  wire par_on = par_mode[1];
  wire [3:0] n_bits = rx_pkg::SIZE_BASE + {2'h0, size_sel} + {3'h0, mpcm_q};
  wire [3:0] last_bit = n_bits - 4'h1;

  wire tick = (div_q == 12'h000);
  wire sample = tick && (ovs_q == rx_pkg::OVS_LAST);
  wire start_edge = (state_q == rx_pkg::RX_IDLE) && !line_q;
  wire [8:0] bit_one = 9'h001 << bit_q;
  wire [8:0] shreg_nx = line_q ? (shreg_q | bit_one) : shreg_q;
  wire par_calc = ^shreg_q ^ par_mode[0];
  wire addr_flag = shreg_q[n_bits[3:0] - 4'h1];
  wire [7:0] data_masked = shreg_q[7:0] & size_mask(size_sel);
  wire frame_done = sample && (state_q == rx_pkg::RX_STOP);

  wire sel_status = (addr == rx_pkg::OFS_STATUS);
  wire sel_ctrl_b = (addr == rx_pkg::OFS_CTRL_B);
  wire sel_ctrl_c = (addr == rx_pkg::OFS_CTRL_C);
  wire sel_data = (addr == rx_pkg::OFS_DATA);
  wire sel_baud_lo = (addr == rx_pkg::OFS_BAUD_LO);
  wire sel_baud_hi = (addr == rx_pkg::OFS_BAUD_HI);

  wire pop = rd && sel_data && fifo_valid;
  wire push = hold_valid_q && fifo_ready;
  wire rx_complete = fifo_valid;
  wire overrun_hit = start_edge && rx_en && fifo_full && hold_valid_q;
  wire keep_frame = !(mpcm_q && !addr_flag);
  // A write that clears the receiver enable flushes in its own cycle, so that a status
  // read right behind it already sees an empty buffer.
  wire rx_off_now = ce && wr && sel_ctrl_b && !wdata[rx_pkg::CB_RXEN_BIT];
  wire flush = !rx_en || rx_off_now;

  assign head = rx_pkg::rx_entry_s'(fifo_out);

  // Status view: error flags come from the oldest buffered entry.
  wire [7:0] status_view = {rx_complete, 2'h0,
                            fifo_valid & head.fe,
                            fifo_valid & head.dor,
                            fifo_valid & head.pe & par_on,
                            1'b0, mpcm_q};

  wire [7:0] rd_mux = sel_status ? status_view :
                      sel_ctrl_b ? ctrl_b_q :
                      sel_ctrl_c ? ctrl_c_q :
                      sel_data ? (fifo_valid ? head.data : 8'h00) :
                      sel_baud_lo ? baud_q[7:0] :
                      sel_baud_hi ? {4'h0, baud_q[11:8]} : 8'h00;

  rx_fifo #(
    .WIDTH(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .flush(flush),
    .push_valid(hold_valid_q),
    .push_ready(fifo_ready),
    .push_data(EW'(hold_q)),
    .pop_valid(fifo_valid),
    .pop_ready(pop),
    .pop_data(fifo_out),
    .full(fifo_full)
  );

  // Register writes; the error flag positions of status are not writable.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_b_q <= rx_pkg::RST_CTRL_B;
      ctrl_c_q <= rx_pkg::RST_CTRL_C;
      baud_q <= rx_pkg::RST_BAUD;
      mpcm_q <= 1'b0;
    end else if (ce && wr) begin
      if (sel_status) begin
        mpcm_q <= wdata[rx_pkg::ST_MPCM_BIT];
      end
      if (sel_ctrl_b) begin
        ctrl_b_q <= wdata;
      end
      if (sel_ctrl_c) begin
        ctrl_c_q <= wdata;
      end
      if (sel_baud_lo) begin
        baud_q[7:0] <= wdata;
      end
      if (sel_baud_hi) begin
        baud_q[11:8] <= wdata[3:0];
      end
    end
  end

  // Read data and interrupt; only the receive complete flag drives the interrupt.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else if (ce) begin
      rdata_q <= rd ? rd_mux : 8'h00;
      irq_q <= rx_complete && rxcie && global_irq_en;
    end
  end

  assign rdata = rdata_q;
  assign rx_irq = irq_q;

  // Three-stage synchroniser; the level changes once stages two and three agree.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      line_q <= 1'b1;
    end else if (ce) begin
      sync1_q <= rxd;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        line_q <= sync3_q;
      end
    end
  end

  // Oversampling divider and bit framing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= rx_pkg::RX_IDLE;
      div_q <= 12'h000;
      ovs_q <= 4'h0;
      bit_q <= 4'h0;
      shreg_q <= 9'h000;
      par_err_q <= 1'b0;
    end else if (ce) begin
      div_q <= (tick || start_edge) ? baud_q : div_q - 12'h001;
      if (tick) begin
        ovs_q <= ovs_q + 4'h1;
      end
      if (!rx_en) begin
        state_q <= rx_pkg::RX_IDLE;
      end else begin
        case (state_q)
          rx_pkg::RX_IDLE: begin
            if (start_edge) begin
              state_q <= rx_pkg::RX_START;
              ovs_q <= 4'h0;
              bit_q <= 4'h0;
              shreg_q <= 9'h000;
              par_err_q <= 1'b0;
            end
          end
          rx_pkg::RX_START: begin
            if (tick && ovs_q == rx_pkg::OVS_MID) begin
              ovs_q <= 4'h0;
              state_q <= line_q ? rx_pkg::RX_IDLE : rx_pkg::RX_DATA;
            end
          end
          rx_pkg::RX_DATA: begin
            if (sample) begin
              shreg_q <= shreg_nx;
              bit_q <= bit_q + 4'h1;
              if (bit_q == last_bit) begin
                state_q <= par_on ? rx_pkg::RX_PARITY : rx_pkg::RX_STOP;
              end
            end
          end
          rx_pkg::RX_PARITY: begin
            if (sample) begin
              par_err_q <= par_calc ^ line_q;
              state_q <= rx_pkg::RX_STOP;
            end
          end
          rx_pkg::RX_STOP: begin
            if (sample) begin
              state_q <= rx_pkg::RX_IDLE;
            end
          end
          default: state_q <= rx_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Holding stage between shift register and buffer, with overrun tracking.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_valid_q <= 1'b0;
      hold_q <= '0;
      ovr_pend_q <= 1'b0;
    end else if (ce) begin
      if (flush) begin
        hold_valid_q <= 1'b0;
        ovr_pend_q <= 1'b0;
      end else begin
        if (push) begin
          hold_valid_q <= 1'b0;
        end
        // The waiting frame carries the overrun into the buffer when it is pushed.
        if (overrun_hit) begin
          ovr_pend_q <= 1'b1;
          hold_q.dor <= 1'b1;
        end else if (push) begin
          ovr_pend_q <= 1'b0;
        end
        if (frame_done && keep_frame && (!hold_valid_q || push)) begin
          hold_valid_q <= 1'b1;
          hold_q.data <= data_masked;
          hold_q.fe <= !line_q;
          hold_q.dor <= ovr_pend_q && !push;
          hold_q.pe <= par_on && par_err_q;
        end
      end
    end
  end

endmodule

// ---- hw/rx_pkg.sv ----
// Purpose: Shared constants and types of the serial receiver status block.
// Assumes: 8-bit register port, 10 MHz system clock, 16x oversampling.
// Notes: Register offsets are word indices on the plain register port.
package rx_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 12;
  localparam int FIFO_DEPTH = 2;

  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_CTRL_B = 3'h1;
  localparam logic [2:0] OFS_CTRL_C = 3'h2;
  localparam logic [2:0] OFS_DATA = 3'h3;
  localparam logic [2:0] OFS_BAUD_LO = 3'h4;
  localparam logic [2:0] OFS_BAUD_HI = 3'h5;

  localparam int ST_RXC_BIT = 7;
  localparam int ST_FE_BIT = 4;
  localparam int ST_DOR_BIT = 3;
  localparam int ST_PE_BIT = 2;
  localparam int ST_MPCM_BIT = 0;

  localparam int CB_RXCIE_BIT = 7;
  localparam int CB_RXEN_BIT = 4;

  localparam int CC_PAR_HI = 5;
  localparam int CC_PAR_LO = 4;
  localparam int CC_STOP2_BIT = 3;
  localparam int CC_SIZE_HI = 2;
  localparam int CC_SIZE_LO = 1;

  localparam logic [1:0] PAR_OFF = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;

  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h06;
  localparam logic [11:0] RST_BAUD = 12'h000;

  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] SIZE_BASE = 4'h5;

  typedef struct packed {
    logic [7:0] data;
    logic fe;
    logic dor;
    logic pe;
  } rx_entry_s;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_e;

endpackage

// ---- hw/rx_fifo.sv ----
// Purpose: Small first-in first-out store for received entries.
// Assumes: Push and pop use valid and ready; flush empties it at once.
// Notes: The oldest entry is always presented on the read side.
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_data,
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [WIDTH-1:0] pop_data,
  output logic full
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin
    $error("rx_fifo needs DEPTH of at least 2 and a positive WIDTH");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;

  wire do_push = push_valid && push_ready;
  wire do_pop = pop_valid && pop_ready;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign full = (cnt_q == (PW+1)'(DEPTH));
  assign push_ready = !full;
  assign pop_valid = (cnt_q != '0);
  assign pop_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (ce && do_push && !flush) begin
      mem_q[wr_q] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (do_push) begin
          wr_q <= nxt(wr_q);
        end
        if (do_pop) begin
          rd_q <= nxt(rd_q);
        end
        cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
    end
  end

endmodule

// ---- bench/uart_rx_status_props.sv ----
// Purpose: Port-level checks of the serial receiver status block.
// Assumes: Shadows of the enable bits follow register writes.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
module uart_rx_status_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic rxd,
  input wire logic global_irq_en,
  input wire logic [rx_pkg::ADDR_W-1:0] addr,
  input wire logic [rx_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [rx_pkg::DATA_W-1:0] rdata,
  input wire logic rx_irq
);
  logic ie_q;
  logic par_q;
  wire logic rd_st = rd && addr == rx_pkg::OFS_STATUS;
  wire logic wr_cb = ce && wr && addr == rx_pkg::OFS_CTRL_B;
  wire logic wr_cc = ce && wr && addr == rx_pkg::OFS_CTRL_C;
  wire logic irq_ok = ie_q && global_irq_en;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ie_q <= 1'b0;
      par_q <= 1'b0;
    end else begin
      if (wr_cb) ie_q <= wdata[rx_pkg::CB_RXCIE_BIT];
      if (wr_cc) par_q <= wdata[rx_pkg::CC_PAR_HI];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_rx_off;
    wr_cb && !wdata[rx_pkg::CB_RXEN_BIT];
  endsequence
  sequence s_status_seen;
    rd_st && irq_ok && !wr ##1 1'b1;
  endsequence

  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside its slot");
  a_unmapped_zero: assert property (rd && addr > 3'h5 |=> rdata == 8'h00)
    else $error("unmapped index read not zero");
  a_status_spare: assert property (rd_st |=> rdata[6:5] == 2'h0 && rdata[1] == 1'b0)
    else $error("spare status bits not zero");
  a_irq_gated: assert property (rx_irq |-> $past(irq_ok))
    else $error("interrupt without both enables");
  a_irq_follows: assert property (s_status_seen |-> rx_irq == rdata[rx_pkg::ST_RXC_BIT])
    else $error("interrupt differs from receive complete flag");
  a_irq_holds: assert property (rx_irq && global_irq_en && !$past(rd) && !$past(wr)
    |=> rx_irq)
    else $error("interrupt dropped with data unread");
  a_disable_empties: assert property (s_rx_off ##1 rd_st |=> !rdata[rx_pkg::ST_RXC_BIT])
    else $error("flag set after receiver disable");
  a_irq_drops_off: assert property (s_rx_off |-> ##[1:3] !rx_irq)
    else $error("interrupt stays after receiver disable");
  a_parity_off: assert property (rd_st && !par_q |=> !rdata[rx_pkg::ST_PE_BIT])
    else $error("parity error shown with parity off");
endmodule

// ---- bench/uart_link_model.sv ----
// Purpose: Remote serial transmitter driving the receive line.
// Assumes: Divider at zero, so a bit lasts 16 clocks.
// Notes: Stop and parity bits can be corrupted on request.
`timescale 1ns/1ps
module uart_link_model (
  input wire logic clk,
  output logic rxd
);
  initial rxd = 1'b1;

  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (16) @(posedge clk);
  endtask

  task automatic send(input logic [7:0] d, input int n, input logic [1:0] par,
                      input logic bad_stop, input logic bad_par, input int n_stop);
    logic p;
    p = ^(d & ((8'h01 << n) - 8'h01)) ^ par[0] ^ bad_par;
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(d[i]);
    if (par[1]) bit_out(p);
    bit_out(~bad_stop);
    // A cut stop bit is followed by the idle level, as a real sender returns to mark.
    if (n_stop > 1 || bad_stop) bit_out(1'b1);
  endtask
endmodule

// ---- bench/uart_rx_status_test.sv ----
// Purpose: Self-checking bench for the serial receiver status block.
// Assumes: Divider left at zero; clock enable held high.
// Notes: Read data are sampled at the falling edge after the strobe.
`timescale 1ns/1ps
module uart_rx_status_test;
  logic clk;
  logic arst_n;
  logic ce;
  logic rxd;
  logic global_irq_en;
  logic [rx_pkg::ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rx_irq;
  logic [7:0] v;
  int n_fail;
  int checks;

  uart_rx_status u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .rxd(rxd),
    .global_irq_en(global_irq_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_irq(rx_irq));
  uart_link_model u_link (.clk(clk), .rxd(rxd));

  task automatic summarize();
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic expect_reg(input string name, input logic [2:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(name, rdata, e);
    @(posedge clk);
  endtask

  // Polls the status location until a character is waiting.
  task automatic wait_rxc();
    for (int i = 0; i < 80; i++) begin
      rd <= 1'b1;
      addr <= rx_pkg::OFS_STATUS;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
      if (v[rx_pkg::ST_RXC_BIT] === 1'b1) return;
    end
    n_fail++;
    summarize();
  endtask

  task automatic irq_is(input string name, input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(name, rx_irq, e);
    @(posedge clk);
  endtask

  task automatic t_regs();
    expect_reg("ctrl_b", rx_pkg::OFS_CTRL_B, rx_pkg::RST_CTRL_B);
    expect_reg("ctrl_c", rx_pkg::OFS_CTRL_C, rx_pkg::RST_CTRL_C);
    expect_reg("status", rx_pkg::OFS_STATUS, 8'h00);
    wr_reg(3'h6, 8'hff);
    expect_reg("unmapped", 3'h6, 8'h00);
  endtask

  task automatic t_flags();
    wr_reg(rx_pkg::OFS_CTRL_C, 8'h2e);
    wr_reg(rx_pkg::OFS_CTRL_B, 8'h10);
    u_link.send(8'ha5, 8, rx_pkg::PAR_EVEN, 1'b0, 1'b0, 2);
    u_link.send(8'h3c, 8, rx_pkg::PAR_EVEN, 1'b1, 1'b1, 2);
    wait_rxc();
    expect_reg("st_a", rx_pkg::OFS_STATUS, 8'h80);
    expect_reg("data_a", rx_pkg::OFS_DATA, 8'ha5);
    wr_reg(rx_pkg::OFS_STATUS, 8'h00);
    expect_reg("st_b", rx_pkg::OFS_STATUS, 8'h94);
    expect_reg("data_b", rx_pkg::OFS_DATA, 8'h3c);
    expect_reg("st_empty", rx_pkg::OFS_STATUS, 8'h00);
  endtask

  task automatic t_overrun();
    logic [7:0] f[4] = '{8'hf5, 8'hea, 8'h1f, 8'h01};
    wr_reg(rx_pkg::OFS_CTRL_C, 8'h00);
    foreach (f[i]) u_link.send(f[i], 5, rx_pkg::PAR_OFF, 1'b0, 1'b0, 1);
    wait_rxc();
    expect_reg("st_1", rx_pkg::OFS_STATUS, 8'h80);
    expect_reg("data_1", rx_pkg::OFS_DATA, 8'h15);
    expect_reg("st_2", rx_pkg::OFS_STATUS, 8'h80);
    expect_reg("data_2", rx_pkg::OFS_DATA, 8'h0a);
    expect_reg("st_3", rx_pkg::OFS_STATUS, 8'h88);
    expect_reg("data_3", rx_pkg::OFS_DATA, 8'h1f);
    expect_reg("st_lost", rx_pkg::OFS_STATUS, 8'h00);
    wr_reg(rx_pkg::OFS_CTRL_C, 8'h30);
    u_link.send(8'hf0, 5, rx_pkg::PAR_ODD, 1'b0, 1'b0, 1);
    wait_rxc();
    expect_reg("st_5", rx_pkg::OFS_STATUS, 8'h80);
    expect_reg("data_5", rx_pkg::OFS_DATA, 8'h10);
  endtask

  task automatic t_mp();
    wr_reg(rx_pkg::OFS_CTRL_C, 8'h08);
    wr_reg(rx_pkg::OFS_STATUS, 8'h01);
    u_link.send(8'h0a, 6, rx_pkg::PAR_OFF, 1'b0, 1'b0, 2);
    u_link.send(8'h21, 6, rx_pkg::PAR_OFF, 1'b0, 1'b0, 2);
    wait_rxc();
    expect_reg("st_addr", rx_pkg::OFS_STATUS, 8'h81);
    expect_reg("data_addr", rx_pkg::OFS_DATA, 8'h01);
    wr_reg(rx_pkg::OFS_STATUS, 8'h00);
    u_link.send(8'h0c, 5, rx_pkg::PAR_OFF, 1'b0, 1'b0, 2);
    wait_rxc();
    expect_reg("data_mp", rx_pkg::OFS_DATA, 8'h0c);
    wr_reg(rx_pkg::OFS_STATUS, 8'h01);
    u_link.send(8'h0a, 6, rx_pkg::PAR_OFF, 1'b0, 1'b0, 2);
    expect_reg("st_skip", rx_pkg::OFS_STATUS, 8'h01);
    wr_reg(rx_pkg::OFS_STATUS, 8'h00);
  endtask

  task automatic t_irq();
    wr_reg(rx_pkg::OFS_CTRL_C, rx_pkg::RST_CTRL_C);
    wr_reg(rx_pkg::OFS_CTRL_B, 8'h90);
    global_irq_en <= 1'b1;
    u_link.send(8'h5a, 8, rx_pkg::PAR_OFF, 1'b0, 1'b0, 1);
    wait_rxc();
    irq_is("irq_set", 1'b1);
    global_irq_en <= 1'b0;
    irq_is("irq_gie", 1'b0);
    global_irq_en <= 1'b1;
    irq_is("irq_again", 1'b1);
    expect_reg("data_irq", rx_pkg::OFS_DATA, 8'h5a);
    irq_is("irq_pop", 1'b0);
    wr_reg(rx_pkg::OFS_CTRL_B, 8'h10);
    u_link.send(8'h00, 8, rx_pkg::PAR_OFF, 1'b1, 1'b0, 1);
    wait_rxc();
    irq_is("irq_err", 1'b0);
    wr <= 1'b1;
    addr <= rx_pkg::OFS_CTRL_B;
    wdata <= 8'h80;
    @(posedge clk);
    wr <= 1'b0;
    expect_reg("st_off", rx_pkg::OFS_STATUS, 8'h00);
    irq_is("irq_off", 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    n_fail = 0;
    checks = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    global_irq_en = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_flags();
    t_overrun();
    t_mp();
    t_irq();
    summarize();
  end
endmodule

bind uart_rx_status uart_rx_status_props u_props (.clk(clk), .arst_n(arst_n), .ce(ce),
  .rxd(rxd), .global_irq_en(global_irq_en), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .rx_irq(rx_irq));
